/* hw/fucs_top.sv */
// FIFO serial unit: APB registers, transmit and receive engines and FIFOs.
`timescale 1ns/1ps
`default_nettype none
module fucs_top (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fucs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        rxdIn,
  output logic                             txdOut,
  input  wire logic                        ctsInN,
  output logic                             rtsOutN,
  output logic                             rxFullIrq,
  output logic                             rxFaultIrq,
  output logic                             breakIrq,
  output logic                             txEmptyIrq
);
  import fucs_pkg::*;

  logic [7:0]              moduleClockStop3;
  logic [15:0]             serialControl;
  logic [15:0]             fifoControl;
  logic [FMT_W-1:0]        frameFormat;
  logic [NFLAGS-1:0]       flags;
  logic [NFLAGS-1:0]       seenOne;
  logic [DATA_W-1:0]       txMem [FIFO_DEPTH];
  logic [DATA_W+1:0]       rxMem [FIFO_DEPTH];
  logic [PTR_W-1:0]        txWp, txRp, rxWp, rxRp;
  logic [CNT_W-1:0]        txCount, rxCount, parCount, frmCount;
  fucs_state_t             txState, rxState;
  logic [DIV_W-1:0]        txBaud, rxBaud;
  logic [2:0]              txBit, rxBit;
  logic [DATA_W-1:0]       txShift, rxShift;
  logic                    txPar, txLine, rxPErr;
  logic [4:0]              idleBits;

  // Register bus decode.
  wire setupPh  = psel & ~penable;
  wire wrAcc    = psel & penable & pwrite;
  wire rdAcc    = psel & penable & ~pwrite;
  wire hitStop  = paddr == ADDR_CLKSTOP;
  wire hitCtrl  = paddr == ADDR_CTRL;
  wire hitFctrl = paddr == ADDR_FCTRL;
  wire hitStat  = paddr == ADDR_STATUS;
  wire hitTx    = paddr == ADDR_TXDATA;
  wire hitRx    = paddr == ADDR_RXDATA;
  wire hitFmt   = paddr == ADDR_FORMAT;
  wire mapped   = hitStop | hitCtrl | hitFctrl | hitStat | hitTx | hitRx | hitFmt;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Control fields.
  wire unitRun     = ~moduleClockStop3[CLKSTOP_UNIT];
  wire txIrqEn     = serialControl[CTRL_TX_IRQ];
  wire rxIrqEn     = serialControl[CTRL_RX_IRQ];
  wire txEnable    = serialControl[CTRL_TX_EN];
  wire rxEnable    = serialControl[CTRL_RX_EN];
  wire faultIrqEn  = serialControl[CTRL_FAULT_IRQ];
  wire [1:0] clkSel = serialControl[CTRL_CKS_HI:CTRL_CKS_LO];
  wire modemEn     = fifoControl[FC_MODEM];
  wire txClear     = fifoControl[FC_TX_CLR];
  wire rxClear     = fifoControl[FC_RX_CLR];
  wire loopBack    = fifoControl[FC_LOOP];
  wire parEn       = frameFormat[FMT_PAR_EN];
  wire parOdd      = frameFormat[FMT_PAR_ODD];
  wire [CNT_W-1:0] rxTrig = RX_TRIG[fifoControl[FC_RXT_HI:FC_RXT_LO]];
  wire [CNT_W-1:0] txTrig = TX_TRIG[fifoControl[FC_TXT_HI:FC_TXT_LO]];
  wire [CNT_W-1:0] rtsTrig = RTS_TRIG[fifoControl[FC_RTS_HI:FC_RTS_LO]];
  // Only the internal divider exists, so every clock-select code runs from it
  // and no serial clock pin is sampled.
  wire [DIV_W-1:0] bitDiv = (clkSel == CKS_INTERNAL) ? frameFormat[DIV_W-1:0]
                                                     : frameFormat[DIV_W-1:0];

  // Serial lines and modem handshake.
  wire rxLine = loopBack ? txLine : rxdIn;
  assign txdOut  = loopBack | txLine;
  wire ctsOk     = ~modemEn | ~ctsInN;
  assign rtsOutN = modemEn & (rxCount >= rtsTrig);

  // FIFO state.
  wire txEmpty  = txCount == '0;
  wire txFull   = txCount == FIFO_DEPTH;
  wire rxEmpty  = rxCount == '0;
  wire rxFull   = rxCount == FIFO_DEPTH;
  wire [DATA_W-1:0] txHead = txMem[txRp];
  wire [DATA_W+1:0] rxHead = rxMem[rxRp];
  wire txPush   = wrAcc & hitTx & ~txFull;
  wire txPop    = unitRun & txEnable & (txState == S_IDLE) & ~txEmpty & ctsOk;
  wire rxPop    = rdAcc & hitRx & ~rxEmpty;
  wire txTick   = txBaud == bitDiv;
  wire rxTick   = rxBaud == bitDiv;
  wire rxMid    = rxBaud == (bitDiv >> 1);
  wire frameEnd = unitRun & rxEnable & (rxState == S_STOP) & rxTick;
  wire frmErr   = ~rxLine;
  wire brkSeen  = frmErr & (rxShift == '0);
  wire rxPush   = frameEnd & ~rxFull;
  wire [DATA_W+1:0] rxEntry = {rxPErr, frmErr, rxShift};

  // Status flag causes.
  wire txLow    = txCount < txTrig;
  wire txIdle   = (txState == S_IDLE) & txEmpty;
  wire rxBusy   = rxState != S_IDLE;
  wire rxLeft   = ~rxEmpty & (rxCount < rxTrig) & ~rxBusy & (idleBits == READY_IDLE_BITS);
  logic [NFLAGS-1:0] setVec, hwClr, swClr;
  assign setVec[SF_FAULT]  = frameEnd & (frmErr | rxPErr);
  assign setVec[SF_DONE]   = txIdle;
  assign setVec[SF_TXLOW]  = txLow;
  assign setVec[SF_BREAK]  = frameEnd & brkSeen;
  assign setVec[SF_FRAME]  = frameEnd & frmErr;
  assign setVec[SF_PARITY] = frameEnd & rxPErr;
  assign setVec[SF_RXFULL] = rxCount >= rxTrig;
  assign setVec[SF_READY]  = rxLeft;
  assign hwClr = {1'b0, txPush | ~txIdle, ~txLow, 4'h0, rxBusy | rxEmpty};
  assign swClr = {NFLAGS{wrAcc & hitStat}} & seenOne & ~pwdata[NFLAGS-1:0]
                 & SW_CLR_MASK;

  // A new event beats a clear arriving in the same cycle.
  for (genvar i = 0; i < NFLAGS; i++) begin : gFlag
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flags[i] <= 1'b0;
      end else begin
        flags[i] <= setVec[i] | (flags[i] & ~(hwClr[i] | swClr[i]));
      end
    end
  end

  wire [3:0] parShow = parCount[CNT_W-1] ? 4'hF : parCount[3:0];
  wire [3:0] frmShow = frmCount[CNT_W-1] ? 4'hF : frmCount[3:0];
  wire [15:0] statusWord = {parShow, frmShow, flags};

  wire [31:0] readMux =
    hitStop  ? {24'h000000, moduleClockStop3} :
    hitCtrl  ? {16'h0000, serialControl} :
    hitFctrl ? {16'h0000, fifoControl} :
    hitStat  ? {16'h0000, statusWord} :
    hitRx    ? {24'h000000, rxHead[DATA_W-1:0]} :
    hitFmt   ? {14'h0000, frameFormat} : 32'h00000000;

  // Interrupt requests.
  assign rxFullIrq  = rxIrqEn & (flags[SF_RXFULL] | flags[SF_READY]);
  assign rxFaultIrq = rxIrqEn & faultIrqEn & (flags[SF_FAULT] | flags[SF_FRAME]
                      | flags[SF_PARITY]);
  assign breakIrq   = rxIrqEn & faultIrqEn & flags[SF_BREAK];
  assign txEmptyIrq = txIrqEn & flags[SF_TXLOW];

  // Registers and read data; read data is captured in the setup cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      moduleClockStop3 <= CLKSTOP_RST;
      serialControl    <= CTRL_RST;
      fifoControl      <= FCTRL_RST;
      frameFormat      <= FORMAT_RST;
      prdata           <= '0;
      seenOne          <= '0;
    end else begin
      if (setupPh) begin
        prdata <= readMux;
      end
      if (wrAcc & hitStop) begin
        moduleClockStop3 <= pwdata[7:0];
      end
      if (wrAcc & hitCtrl) begin
        serialControl <= pwdata[15:0] & CTRL_MASK;
      end
      if (wrAcc & hitFctrl) begin
        fifoControl <= pwdata[15:0] & FCTRL_MASK;
      end
      if (wrAcc & hitFmt) begin
        frameFormat <= pwdata[FMT_W-1:0];
      end
      if (rdAcc & hitStat) begin
        seenOne <= flags;
      end else if (wrAcc & hitStat) begin
        seenOne <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (txPush) begin
      txMem[txWp] <= pwdata[DATA_W-1:0];
    end
    if (rxPush) begin
      rxMem[rxWp] <= rxEntry;
    end
  end

  // Transmit FIFO pointers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txWp    <= '0;
      txRp    <= '0;
      txCount <= '0;
    end else if (txClear) begin
      txWp    <= '0;
      txRp    <= '0;
      txCount <= '0;
    end else begin
      txWp    <= txWp + PTR_W'(txPush);
      txRp    <= txRp + PTR_W'(txPop);
      txCount <= txCount + CNT_W'(txPush) - CNT_W'(txPop);
    end
  end

  // Receive FIFO pointers and error tallies of the held entries.
  wire popPar = rxPop & rxHead[DATA_W+1];
  wire popFrm = rxPop & rxHead[DATA_W];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWp     <= '0;
      rxRp     <= '0;
      rxCount  <= '0;
      parCount <= '0;
      frmCount <= '0;
    end else if (rxClear) begin
      rxWp     <= '0;
      rxRp     <= '0;
      rxCount  <= '0;
      parCount <= '0;
      frmCount <= '0;
    end else begin
      rxWp     <= rxWp + PTR_W'(rxPush);
      rxRp     <= rxRp + PTR_W'(rxPop);
      rxCount  <= rxCount + CNT_W'(rxPush) - CNT_W'(rxPop);
      parCount <= parCount + CNT_W'(rxPush & rxPErr) - CNT_W'(popPar);
      frmCount <= frmCount + CNT_W'(rxPush & frmErr) - CNT_W'(popFrm);
    end
  end

  // Transmit engine: start, data LSB first, optional parity, one stop bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= S_IDLE;
      txLine  <= 1'b1;
      txBaud  <= '0;
      txBit   <= '0;
      txShift <= '0;
      txPar   <= 1'b0;
    end else if (!txEnable) begin
      txState <= S_IDLE;
      txLine  <= 1'b1;
      txBaud  <= '0;
    end else if (unitRun) begin
      txBaud <= (txTick || txState == S_IDLE) ? '0 : txBaud + 1'b1;
      unique case (txState)
        S_IDLE: if (txPop) begin
          txShift <= txHead;
          txPar   <= (^txHead) ^ parOdd;
          txLine  <= 1'b0;
          txState <= S_START;
        end
        S_START: if (txTick) begin
          txLine  <= txShift[0];
          txShift <= txShift >> 1;
          txBit   <= '0;
          txState <= S_DATA;
        end
        S_DATA: if (txTick) begin
          if (txBit == LAST_BIT) begin
            txLine  <= parEn ? txPar : 1'b1;
            txState <= parEn ? S_PAR : S_STOP;
          end else begin
            txLine  <= txShift[0];
            txShift <= txShift >> 1;
            txBit   <= txBit + 1'b1;
          end
        end
        S_PAR: if (txTick) begin
          txLine  <= 1'b1;
          txState <= S_STOP;
        end
        S_STOP: if (txTick) begin
          txState <= S_IDLE;
        end
      endcase
    end
  end

  // Receive engine: start bit checked at mid-bit, then one sample per bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState  <= S_IDLE;
      rxBaud   <= '0;
      rxBit    <= '0;
      rxShift  <= '0;
      rxPErr   <= 1'b0;
      idleBits <= '0;
    end else if (!rxEnable) begin
      rxState  <= S_IDLE;
      rxBaud   <= '0;
      idleBits <= '0;
    end else if (unitRun) begin
      rxBaud <= rxTick ? '0 : rxBaud + 1'b1;
      unique case (rxState)
        S_IDLE: begin
          if (!rxLine) begin
            rxBaud  <= '0;
            rxPErr  <= 1'b0;
            rxState <= S_START;
          end else if (rxTick && idleBits != READY_IDLE_BITS) begin
            idleBits <= idleBits + 1'b1;
          end
        end
        S_START: if (rxMid) begin
          rxBaud   <= '0;
          rxBit    <= '0;
          idleBits <= '0;
          rxState  <= rxLine ? S_IDLE : S_DATA;
        end
        S_DATA: if (rxTick) begin
          rxShift <= {rxLine, rxShift[DATA_W-1:1]};
          rxBit   <= rxBit + 1'b1;
          if (rxBit == LAST_BIT) begin
            rxState <= parEn ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (rxTick) begin
          rxPErr  <= (^rxShift) ^ rxLine ^ parOdd;
          rxState <= S_STOP;
        end
        S_STOP: if (rxTick) begin
          rxState <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* hw/fucs_pkg.sv */
// Constants, register map and state encoding of the FIFO serial unit.
package fucs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PTR_W  = 4;
  localparam int CNT_W  = 5;
  localparam int DIV_W  = 16;
  localparam int FMT_W  = 18;

  localparam logic [ADDR_W-1:0] ADDR_CLKSTOP = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FCTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_TXDATA  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT  = 8'h18;

  localparam logic [7:0]       CLKSTOP_RST = 8'hFF;
  localparam logic [15:0]      CTRL_RST    = 16'h0000;
  localparam logic [15:0]      FCTRL_RST   = 16'h0000;
  localparam logic [FMT_W-1:0] FORMAT_RST  = 18'h00063;
  localparam logic [15:0]      CTRL_MASK   = 16'h00FB;
  localparam logic [15:0]      FCTRL_MASK  = 16'h07FF;
  localparam logic [7:0]       SW_CLR_MASK = 8'h9F;

  localparam int CLKSTOP_UNIT   = 6;
  localparam int CTRL_TX_IRQ    = 7;
  localparam int CTRL_RX_IRQ    = 6;
  localparam int CTRL_TX_EN     = 5;
  localparam int CTRL_RX_EN     = 4;
  localparam int CTRL_FAULT_IRQ = 3;
  localparam int CTRL_CKS_HI    = 1;
  localparam int CTRL_CKS_LO    = 0;
  localparam int FC_RTS_HI      = 10;
  localparam int FC_RTS_LO      = 8;
  localparam int FC_RXT_HI      = 7;
  localparam int FC_RXT_LO      = 6;
  localparam int FC_TXT_HI      = 5;
  localparam int FC_TXT_LO      = 4;
  localparam int FC_MODEM       = 3;
  localparam int FC_TX_CLR      = 2;
  localparam int FC_RX_CLR      = 1;
  localparam int FC_LOOP        = 0;
  localparam int FMT_PAR_EN     = 16;
  localparam int FMT_PAR_ODD    = 17;

  localparam int SF_FAULT  = 7;
  localparam int SF_DONE   = 6;
  localparam int SF_TXLOW  = 5;
  localparam int SF_BREAK  = 4;
  localparam int SF_FRAME  = 3;
  localparam int SF_PARITY = 2;
  localparam int SF_RXFULL = 1;
  localparam int SF_READY  = 0;
  localparam int NFLAGS    = 8;

  localparam logic [1:0] CKS_INTERNAL = 2'h0;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [4:0] READY_IDLE_BITS = 5'h0F;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;

  localparam logic [CNT_W-1:0] RX_TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [CNT_W-1:0] TX_TRIG [4] = '{5'h08, 5'h04, 5'h02, 5'h00};
  localparam logic [CNT_W-1:0] RTS_TRIG [8] =
    '{5'h0F, 5'h01, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E};

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_DATA  = 5'b00100,
    S_PAR   = 5'b01000,
    S_STOP  = 5'b10000
  } fucs_state_t;
endpackage

/* test/fucs_checker.sv */
// Port-level assertions for the FIFO serial unit.
`timescale 1ns/1ps
`default_nettype none
module fucs_checker (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [fucs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        rxdIn,
  input wire logic                        txdOut,
  input wire logic                        ctsInN,
  input wire logic                        rtsOutN,
  input wire logic                        rxFullIrq,
  input wire logic                        rxFaultIrq,
  input wire logic                        breakIrq,
  input wire logic                        txEmptyIrq
);
  import fucs_pkg::*;
  logic [7:0]  clkSh;
  logic [15:0] ctrlSh;
  logic [15:0] fctrlSh;
  wire         wrEn = psel && penable && pwrite && pready;

  // The checker sees no registers, so it rebuilds clock-stop, control and FIFO control from the bus writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSh <= CLKSTOP_RST;
      ctrlSh <= CTRL_RST;
      fctrlSh <= FCTRL_RST;
    end else if (wrEn) begin
      if (paddr == ADDR_CLKSTOP) clkSh <= pwdata[7:0];
      if (paddr == ADDR_CTRL) ctrlSh <= pwdata[15:0] & CTRL_MASK;
      if (paddr == ADDR_FCTRL) fctrlSh <= pwdata[15:0] & FCTRL_MASK;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  tx_irq_gate_a: assert property (!ctrlSh[CTRL_TX_IRQ] |-> !txEmptyIrq)
    else $error("transmit request while masked");
  rx_irq_gate_a: assert property (!ctrlSh[CTRL_RX_IRQ] |-> !(rxFullIrq || rxFaultIrq || breakIrq))
    else $error("receive request while masked");
  fault_irq_gate_a: assert property (!ctrlSh[CTRL_FAULT_IRQ] |-> !rxFaultIrq && !breakIrq)
    else $error("fault request while masked");
  tx_off_idle_a: assert property (!ctrlSh[CTRL_TX_EN] && !$past(ctrlSh[CTRL_TX_EN]) |-> txdOut)
    else $error("line active while sending is off");
  rts_off_a: assert property (!fctrlSh[FC_MODEM] |-> !rtsOutN)
    else $error("handshake output moved while disabled");
  loop_quiet_a: assert property (fctrlSh[FC_LOOP] |-> txdOut)
    else $error("line active during loopback");
  unit_stop_a: assert property (clkSh[CLKSTOP_UNIT] && $past(clkSh[CLKSTOP_UNIT])
      && $stable(fctrlSh[FC_LOOP]) && $stable(ctrlSh[CTRL_TX_EN])
      && $past(ctrlSh[CTRL_TX_EN], 2) == ctrlSh[CTRL_TX_EN] |-> $stable(txdOut))
    else $error("line moved while unit stopped");
  tx_low_irq_a: assert property (ctrlSh[CTRL_TX_IRQ] && fctrlSh[FC_TX_CLR]
      && $past(fctrlSh[FC_TX_CLR], 2) && $stable(fctrlSh)
      && fctrlSh[FC_TXT_HI:FC_TXT_LO] != 2'h3 |-> txEmptyIrq)
    else $error("cleared transmit queue not reported low");
endmodule
`default_nettype wire

/* test/fucs_remote.sv */
// Remote serial station: sends frames to the unit and decodes its output.
`timescale 1ns/1ps
`default_nettype none
module fucs_remote #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;

  task automatic send(input logic [7:0] b, input logic stopBit);
    int i;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= stopBit;
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Sampling on the falling edge keeps clear of the unit's own output updates.
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    int i;
    n = 0;
    b = 8'h00;
    do begin
      @(negedge clk);
      n++;
    end while (txd !== 1'b0 && n < 500);
    repeat (BIT_CLKS / 2) @(negedge clk);
    ok = (txd === 1'b0) && (n < 500);
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(negedge clk);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(negedge clk);
    ok = ok && (txd === 1'b1);
  endtask
endmodule
`default_nettype wire

/* test/test_fucs_top.sv */
// Self-checking bench for the FIFO serial unit.
`timescale 1ns/1ps
`default_nettype none
module test_fucs_top;
  import fucs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, c, f;
  logic        pready, pslverr, rxdIn, txdOut, rtsOutN, e, ok;
  logic        ctsInN = 1'b0;
  logic        rxFullIrq, rxFaultIrq, breakIrq, txEmptyIrq;
  logic [31:0] seed = 32'hC74AAF02;
  logic [7:0]  b;
  logic [7:0]  q[$];
  int          numErrors = 0;
  int          testsRun = 0;
  int          i;

  always #2.5 clk = ~clk;

  fucs_top i_fucs_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxdIn(rxdIn), .txdOut(txdOut), .ctsInN(ctsInN), .rtsOutN(rtsOutN),
    .rxFullIrq(rxFullIrq), .rxFaultIrq(rxFaultIrq), .breakIrq(breakIrq),
    .txEmptyIrq(txEmptyIrq));
  fucs_remote i_fucs_remote (.clk(clk), .txd(txdOut), .rxd(rxdIn));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // With the transmit queue empty, only trigger code 11 (zero) keeps the low flag off.
  function logic txIrqExp(input logic [15:0] cw, input logic [15:0] fw);
    return cw[CTRL_TX_IRQ] && (fw[FC_TXT_HI:FC_TXT_LO] != 2'h3);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reportAndStop();
    if (numErrors == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      numErrors++;
      reportAndStop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Flags other than done and transmit-low are cleared by seeing them set first, then writing zero.
  task automatic clearFlags();
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    numErrors++;
    reportAndStop();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_CLKSTOP, 32'h0);
    check(r, {24'h0, CLKSTOP_RST});
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r, 32'h00000060);
    apb(1'b0, 8'h40, 32'h0);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    for (i = 0; i < 6; i++) begin
      f = rnd();
      c = rnd();
      apb(1'b1, ADDR_FCTRL, f);
      apb(1'b1, ADDR_CTRL, c);
      apb(1'b0, ADDR_FCTRL, 32'h0);
      check(r, {16'h0, f[15:0] & FCTRL_MASK});
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(r, {16'h0, c[15:0] & CTRL_MASK});
      check({31'h0, txEmptyIrq}, {31'h0, txIrqExp(c[15:0], f[15:0])});
    end
    apb(1'b1, ADDR_FCTRL, 32'h00000080);
    apb(1'b1, ADDR_CTRL, 32'h00000080);
    apb(1'b1, ADDR_FORMAT, 32'h00000003);
    apb(1'b1, ADDR_CLKSTOP, 32'h000000BF);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_TXDATA, rnd());
      apb(1'b0, ADDR_STATUS, 32'h0);
      check({31'h0, r[SF_TXLOW]}, {31'h0, i < 7});
    end
    check({30'h0, txdOut, txEmptyIrq}, 32'h2);
    apb(1'b1, ADDR_FCTRL, 32'h00000084);
    apb(1'b1, ADDR_FCTRL, 32'h00000080);
    check({31'h0, txEmptyIrq}, 32'h1);
    c = rnd();
    apb(1'b1, ADDR_TXDATA, c);
    fork
      i_fucs_remote.recv(b, ok);
      begin
        apb(1'b1, ADDR_CTRL, 32'h00000020);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, r[SF_DONE]}, 32'h0);
      end
    join
    check({23'h0, ok, b}, {24'h1, c[7:0]});
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({31'h0, r[SF_DONE]}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h00000050);
    for (i = 0; i < 8; i++) begin
      c = rnd();
      q.push_back(c[7:0]);
      i_fucs_remote.send(c[7:0], 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check({31'h0, r[SF_RXFULL]}, {31'h0, i == 7});
    end
    check({31'h0, rxFullIrq}, 32'h1);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, ADDR_RXDATA, 32'h0);
      check(r, {24'h0, q.pop_front()});
    end
    clearFlags();
    check({29'h0, r[1:0], rxFullIrq}, 32'h0);
    c = rnd();
    i_fucs_remote.send(c[7:0], 1'b1);
    repeat (80) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({29'h0, r[1:0], rxFullIrq}, 32'h3);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    check(r, {24'h0, c[7:0]});
    clearFlags();
    check({31'h0, r[SF_READY]}, 32'h0);
    i_fucs_remote.send(8'h5A, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r & 32'h0000FFFC, 32'h000001E8);
    check({31'h0, rxFaultIrq}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h00000058);
    check({31'h0, rxFaultIrq}, 32'h1);
    i_fucs_remote.send(8'h00, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r & 32'h0000FFFC, 32'h000002F8);
    check({31'h0, breakIrq}, 32'h1);
    // With parity on, the stop slot of send carries the parity bit instead.
    apb(1'b1, ADDR_FORMAT, 32'h00010003);
    i_fucs_remote.send(8'h01, 1'b0);
    repeat (8) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r & 32'h0000FFFC, 32'h000012FC);
    apb(1'b1, ADDR_FCTRL, 32'h00000082);
    apb(1'b1, ADDR_FCTRL, 32'h00000080);
    clearFlags();
    check(r, 32'h00000060);
    check({30'h0, breakIrq, rxFaultIrq}, 32'h0);
    // Loopback with handshake: a high clear-to-send must hold the frame back.
    ctsInN <= 1'b1;
    apb(1'b1, ADDR_FCTRL, 32'h00000189);
    apb(1'b1, ADDR_CTRL, 32'h00000070);
    c = rnd();
    apb(1'b1, ADDR_TXDATA, c);
    repeat (60) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({30'h0, r[SF_DONE], rtsOutN}, 32'h0);
    ctsInN <= 1'b0;
    repeat (20) @(posedge clk);
    check({31'h0, txdOut}, 32'h1);
    repeat (40) @(posedge clk);
    check({31'h0, rtsOutN}, 32'h1);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    check(r, {24'h0, c[7:0]});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_CLKSTOP, 32'h0);
    check(r, {24'h0, CLKSTOP_RST});
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r, 32'h00000060);
    reportAndStop();
  end
endmodule

bind fucs_top fucs_checker i_fucs_checker (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxdIn(rxdIn), .txdOut(txdOut), .ctsInN(ctsInN),
  .rtsOutN(rtsOutN), .rxFullIrq(rxFullIrq), .rxFaultIrq(rxFaultIrq),
  .breakIrq(breakIrq), .txEmptyIrq(txEmptyIrq));
`default_nettype wire
